// file: src/fndc_defines.vh
/*
 * Constants for the feedback divider and loop-mode control block.
 * Assumes it is included by bare name from the design files.
 */
`ifndef FNDC_DEFINES_VH
`define FNDC_DEFINES_VH

`define FNDC_N_W 12
`define FNDC_DEN_W 32
`define FNDC_ACC_W 33
`define FNDC_N_RST 12'h064
`define FNDC_DEN_RST 32'h000003e8
`define FNDC_NUM_RST 32'h00000000
`define FNDC_ORDER_RST 3'h0
`define FNDC_MOD_INT 3'h0
`define FNDC_MOD_FIRST 3'h1
`define FNDC_MOD_SECOND 3'h2
`define FNDC_MOD_THIRD 3'h3
`define FNDC_MOD_FOURTH 3'h4
`define FNDC_LOOP_DUAL 2'h0
`define FNDC_LOOP_SINGLE 2'h3
`define FNDC_ADJ_EXT 2'h3
`define FNDC_CAL_ADDR 7'h00
`define FNDC_CAL_BIT 3
`define FNDC_CAL_SETTLE_NS 1000
`define FNDC_CAL_SETTLE_CYC ((`FNDC_CAL_SETTLE_NS + 9) / 10)
`define FNDC_CAL_STEPS 5'h10
`define FNDC_TUNE_MID 8'h80

`endif

// file: src/fndc_mash.v
/*
 * Multi-stage noise-shaping modulator of selectable order 1 to 4.
 * Assumes step is a one-cycle pulse, once per feedback-divider cycle.
 */
`timescale 1ns/1ps
`include "fndc_defines.vh"

module fndc_mash (
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // Control.
    input wire step,
    input wire [2:0] order,
    input wire [31:0] num,
    input wire [31:0] den,
    // Result.
    output reg signed [4:0] offset_q
);

reg [31:0] acc_q [0:3];
reg [3:0] cy_q;
reg [3:0] cy_d1_q;
reg [3:0] cy_d2_q;
reg [3:0] cy_d3_q;
reg [31:0] in_v;
reg [32:0] sum_v;
reg [3:0] cy_v;
reg [31:0] nxt_v [0:3];
reg signed [6:0] sum_o;
integer i;
integer j;

function signed [6:0] fndc_diff;
    input c;
    input p;
    begin
        fndc_diff = $signed({6'h00, c}) - $signed({6'h00, p});
    end
endfunction

always @* begin
    in_v = num;
    cy_v = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
        sum_v = {1'b0, acc_q[i]} + {1'b0, in_v};
        if (sum_v >= {1'b0, den}) begin
            cy_v[i] = 1'b1;
            sum_v = sum_v - {1'b0, den};
        end
        nxt_v[i] = sum_v[31:0];
        in_v = acc_q[i];
    end
end

// Noise-shaping recombination of the stage carries.
always @* begin
    sum_o = $signed({6'h00, cy_q[0]});
    if (order >= `FNDC_MOD_SECOND)
        sum_o = sum_o + fndc_diff(cy_q[1], cy_d1_q[1]);
    if (order >= `FNDC_MOD_THIRD)
        sum_o = sum_o + fndc_diff(cy_q[2], cy_d1_q[2]) - fndc_diff(cy_d1_q[2], cy_d2_q[2]);
    if (order >= `FNDC_MOD_FOURTH)
        sum_o = sum_o + fndc_diff(cy_q[3], cy_d1_q[3]) - 7'sd2 * fndc_diff(cy_d1_q[3], cy_d2_q[3])
              + fndc_diff(cy_d2_q[3], cy_d3_q[3]);
end

always @(posedge mclk) begin
    if (rst) begin
        for (j = 0; j < 4; j = j + 1)
            acc_q[j] <= 32'h00000000;
        cy_q <= 4'h0;
        cy_d1_q <= 4'h0;
        cy_d2_q <= 4'h0;
        cy_d3_q <= 4'h0;
        offset_q <= 5'sd0;
    end else if (step) begin
        for (j = 0; j < 4; j = j + 1)
            acc_q[j] <= (order == `FNDC_MOD_INT || den == 32'h0) ? 32'h0 : nxt_v[j];
        cy_q <= (order == `FNDC_MOD_INT) ? 4'h0 : cy_v;
        cy_d1_q <= cy_q;
        cy_d2_q <= cy_d1_q;
        cy_d3_q <= cy_d2_q;
        offset_q <= (order == `FNDC_MOD_INT) ? 5'sd0 : sum_o[4:0];
    end
end

endmodule // fndc_mash

// file: src/fndc_top.v
/*
 * Feedback divider with prescaler and modulator, loop-mode outputs,
 * reference-path bypass selects and the frequency calibration sequencer.
 * Assumes the register bank delivers fields as ports and strobes a write
 * with an address; reference and oscillator edges arrive as mclk-synchronous
 * one-cycle pulses.
 */
// Contract
// - Integer divider value is twelve bits wide.
// - Modulator order selectable from first to fourth.
// - Denominator accepts any value from one up to all-ones, 32 bits.
// - Average division equals integer plus numerator over denominator.
// - Prescaler ahead of divider divides oscillator by two or four.
// - Dual-loop detection is the default unless extended mode set; code leaves dual loop only when detector_loop_select selects single loop.
// - Writing control register zero with trigger set starts calibration.
// - Calibration parks the tuning point mid first, then adjusts oscillator.
// - Doubler enabled forces prescaler to divide by four.
// - Each reference-path stage can be bypassed independently.
// - Input doubler acts on both edges, doubling the reference rate.
// - Output phase shifts in steps of the fractional denominator.
`timescale 1ns/1ps
`include "fndc_defines.vh"

module fndc_top (
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // Divider settings.
    input wire [11:0] int_div,
    input wire [31:0] frac_num,
    input wire [31:0] fraction_denominator,
    input wire [2:0] mod_order,
    input wire presc_div4,
    input wire oscillator_doubler_enable,
    input wire [31:0] phase_seed,
    input wire phase_seed_load,
    // Loop mode settings.
    input wire [1:0] detector_loop_select,
    input wire [1:0] cal_low_compare_adjust,
    input wire [1:0] cal_high_compare_adjust,
    input wire [3:0] detector_delay_select,
    // Reference path bypass controls.
    input wire ref_doubler_en,
    input wire ref_prediv_en,
    input wire ref_mult_en,
    input wire ref_postdiv_en,
    input wire [7:0] ref_prediv,
    input wire [7:0] ref_postdiv,
    // Register bank write strobe.
    input wire reg_wr,
    input wire [6:0] reg_addr,
    input wire [15:0] reg_data,
    // Event inputs.
    input wire osc_edge,
    input wire reference_input_rise,
    input wire reference_input_fall,
    input wire mult_edge,
    input wire cal_freq_high,
    // Divider outputs.
    output reg fb_pulse_q,
    output reg [11:0] inst_div_q,
    // Reference path output.
    output reg ref_pulse_q,
    // Loop mode outputs.
    output reg dual_loop_q,
    output reg [3:0] delay_sel_q,
    // Calibration outputs.
    output reg cal_busy_q,
    output reg cal_done_q,
    output reg tune_force_q,
    output reg [7:0] osc_band_q
);

////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 4'b0001;
localparam ST_PARK = 4'b0010;
localparam ST_SEARCH = 4'b0100;
localparam ST_DONE = 4'b1000;

reg [1:0] pre_cnt_q;
reg pre_tick;
reg [11:0] n_cnt_q;
reg mash_step;
wire signed [4:0] mash_off;
reg [12:0] div_sum;
reg seed_pend_q;

////////////////////////////////////////////////////////////////////////////
// Prescaler; doubler forces divide by four.
always @* begin
    pre_tick = 1'b0;
    if (osc_edge) begin
        if (presc_div4 || oscillator_doubler_enable)
            pre_tick = (pre_cnt_q == 2'h3);
        else
            pre_tick = pre_cnt_q[0];
    end
end

always @(posedge mclk) begin
    if (rst)
        pre_cnt_q <= 2'h0;
    else if (osc_edge)
        pre_cnt_q <= pre_tick ? 2'h0 : pre_cnt_q + 2'h1;
end

////////////////////////////////////////////////////////////////////////////
// Twelve-bit divider reloaded each cycle from the dithered value.
always @* begin
    mash_step = pre_tick && (n_cnt_q <= 12'h001);
    div_sum = {1'b0, int_div} + {{8{mash_off[4]}}, mash_off};
end

always @(posedge mclk) begin
    if (rst) begin
        n_cnt_q <= 12'h000;
        inst_div_q <= `FNDC_N_RST;
        fb_pulse_q <= 1'b0;
    end else begin
        fb_pulse_q <= mash_step;
        if (pre_tick) begin
            if (mash_step) begin
                n_cnt_q <= div_sum[11:0];
                inst_div_q <= div_sum[11:0];
            end else begin
                n_cnt_q <= n_cnt_q - 12'h001;
            end
        end
    end
end

// One extra numerator of seed added on the next step shifts phase.
function [31:0] phase_pend_num;
    input pend;
    input [31:0] num;
    input [31:0] seed;
    begin
        phase_pend_num = pend ? num + seed : num;
    end
endfunction

fndc_mash u_mash (
    .mclk(mclk),
    .rst(rst),
    .step(mash_step),
    .order(mod_order),
    .num(phase_pend_num(seed_pend_q, frac_num, phase_seed)),
    .den(fraction_denominator),
    .offset_q(mash_off)
);

always @(posedge mclk) begin
    if (rst) begin
        seed_pend_q <= 1'b0;
    end else begin
        if (phase_seed_load)
            seed_pend_q <= 1'b1;
        else if (mash_step)
            seed_pend_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// Reference path: doubler, pre-divider, multiplier, post-divider.
reg [7:0] pre_cnt_r_q;
reg [7:0] post_cnt_q;
reg s1;
reg s2;
reg s3;
reg [8:0] pre_step;
reg [8:0] post_step;

function [8:0] fndc_divstep;
    input in;
    input [7:0] cnt;
    input [7:0] div;
    begin
        if (!in)
            fndc_divstep = {1'b0, cnt};
        else if (cnt + 8'h01 >= div)
            fndc_divstep = {1'b1, 8'h00};
        else
            fndc_divstep = {1'b0, cnt + 8'h01};
    end
endfunction

always @* begin
    s1 = ref_doubler_en ? (reference_input_rise | reference_input_fall)
                        : reference_input_rise;
    pre_step = fndc_divstep(s1, pre_cnt_r_q, ref_prediv);
    s2 = ref_prediv_en ? pre_step[8] : s1;
    s3 = ref_mult_en ? mult_edge : s2;
    post_step = fndc_divstep(s3, post_cnt_q, ref_postdiv);
end

always @(posedge mclk) begin
    if (rst) begin
        pre_cnt_r_q <= 8'h00;
        post_cnt_q <= 8'h00;
        ref_pulse_q <= 1'b0;
    end else begin
        pre_cnt_r_q <= pre_step[7:0];
        post_cnt_q <= post_step[7:0];
        ref_pulse_q <= ref_postdiv_en ? post_step[8] : s3;
    end
end

////////////////////////////////////////////////////////////////////////////
// Loop mode: dual loop unless single loop selected.
always @(posedge mclk) begin
    if (rst) begin
        dual_loop_q <= 1'b1;
        delay_sel_q <= 4'h1;
    end else begin
        dual_loop_q <= (detector_loop_select != `FNDC_LOOP_SINGLE);
        delay_sel_q <= detector_delay_select;
    end
end

////////////////////////////////////////////////////////////////////////////
// Calibration sequencer, stepped by reference pulses.
reg [3:0] cal_st_q;
reg [15:0] cal_cnt_q;
reg [4:0] cal_step_q;
reg cal_req;

always @* begin
    cal_req = reg_wr && (reg_addr == `FNDC_CAL_ADDR) && reg_data[`FNDC_CAL_BIT];
end

always @(posedge mclk) begin
    if (rst) begin
        cal_st_q <= ST_IDLE;
        cal_cnt_q <= 16'h0000;
        cal_step_q <= 5'h00;
        cal_busy_q <= 1'b0;
        cal_done_q <= 1'b0;
        tune_force_q <= 1'b0;
        osc_band_q <= `FNDC_TUNE_MID;
    end else if (cal_req) begin
        cal_st_q <= ST_PARK;
        cal_cnt_q <= 16'h0000;
        cal_step_q <= 5'h00;
        cal_busy_q <= 1'b1;
        cal_done_q <= 1'b0;
        tune_force_q <= 1'b1;
        osc_band_q <= `FNDC_TUNE_MID;
    end else begin
        case (cal_st_q)
            ST_IDLE: begin
                cal_done_q <= 1'b0;
            end
            ST_PARK: begin
                if (reference_input_rise)
                    cal_cnt_q <= cal_cnt_q + 16'h0001;
                if (cal_cnt_q >= `FNDC_CAL_SETTLE_CYC)
                    cal_st_q <= ST_SEARCH;
            end
            ST_SEARCH: begin
                if (reference_input_rise) begin
                    cal_step_q <= cal_step_q + 5'h01;
                    osc_band_q <= cal_freq_high ? osc_band_q - 8'h01 : osc_band_q + 8'h01;
                    if (cal_step_q == `FNDC_CAL_STEPS - 5'h01)
                        cal_st_q <= ST_DONE;
                end
            end
            ST_DONE: begin
                tune_force_q <= 1'b0;
                cal_busy_q <= 1'b0;
                cal_done_q <= 1'b1;
                cal_st_q <= ST_IDLE;
            end
            default: begin
                cal_st_q <= ST_IDLE;
            end
        endcase
    end
end

endmodule // fndc_top

// file: testbench/fndc_osc_model.sv
/* Event model of the oscillator, reference input and multiplier.
   Assumes mclk-synchronous pulses feed fndc_top. */
`timescale 1ns/1ps
module fndc_osc_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Events.
    output logic osc_edge,
    output logic reference_input_rise,
    output logic reference_input_fall,
    output logic mult_edge,
    output logic cal_freq_high
);
    logic [2:0] cnt_q;
    always @(posedge mclk) begin
        cnt_q <= rst ? 3'h0 : cnt_q + 3'h1;
    end
    // The reference runs from reset on with a square duty cycle.
    assign osc_edge = 1'b1;
    assign reference_input_rise = cnt_q == 3'h0;
    assign reference_input_fall = cnt_q == 3'h4;
    assign mult_edge = cnt_q[0];
    assign cal_freq_high = cnt_q[2];
endmodule // fndc_osc_model

// file: testbench/fndc_top_properties.sv
/* Concurrent checks on the ports of fndc_top.
   Assumes one clock mclk and synchronous active-high rst. */
`timescale 1ns/1ps
module fndc_top_properties (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Inputs watched.
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_data,
    input wire logic [1:0] detector_loop_select,
    // Outputs watched.
    input wire logic fb_pulse_q,
    input wire logic dual_loop_q,
    input wire logic cal_busy_q,
    input wire logic cal_done_q,
    input wire logic tune_force_q,
    input wire logic [7:0] osc_band_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence cal_req;
        reg_wr && reg_addr == 7'h00 && reg_data[3];
    endsequence
    sequence cal_run;
        cal_busy_q && tune_force_q;
    endsequence
    a_cal_start: assert property (cal_req |=> cal_run)
        else $error("calibration did not start");
    a_tune_mid: assert property (cal_req |=> osc_band_q == 8'h80)
        else $error("band not parked at mid value");
    a_bad_write: assert property (reg_wr && !cal_busy_q &&
        (reg_addr != 7'h00 || !reg_data[3]) |=> !cal_busy_q)
        else $error("ignored write started calibration");
    a_done_pulse: assert property (cal_done_q |=> !cal_done_q)
        else $error("done longer than one cycle");
    a_done_clear: assert property (cal_done_q |-> !cal_busy_q && !tune_force_q)
        else $error("busy or force left at done");
    a_force_busy: assert property (cal_busy_q |-> tune_force_q)
        else $error("tuning not forced during calibration");
    a_loop_single: assert property (detector_loop_select == 2'h3 |=> !dual_loop_q)
        else $error("single loop not taken");
    a_loop_dual: assert property (detector_loop_select == 2'h0 |=> dual_loop_q)
        else $error("dual loop not default");
    a_fb_gap: assert property (fb_pulse_q |=> (!fb_pulse_q) [*8])
        else $error("divider cycle too short");
endmodule // fndc_top_properties
bind fndc_top fndc_top_properties fndc_top_properties_inst (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_data(reg_data),
    .detector_loop_select(detector_loop_select), .fb_pulse_q(fb_pulse_q),
    .dual_loop_q(dual_loop_q), .cal_busy_q(cal_busy_q), .cal_done_q(cal_done_q),
    .tune_force_q(tune_force_q), .osc_band_q(osc_band_q)
);

// file: testbench/tb.sv
/* Self-checking bench for fndc_top with the event model.
   Assumes the design and checker files are compiled first. */
`timescale 1ns/1ps
module tb;
    typedef struct {logic [11:0] n; logic [2:0] o; logic d4; logic dx; int w; int tol;} row_t;
    logic mclk = 1'b0, rst = 1'b1, presc_div4 = 1'b0, oscillator_doubler_enable = 1'b0;
    logic [11:0] int_div = 12'h028;
    logic [31:0] frac_num = 32'h3, fraction_denominator = 32'h8, phase_seed = 32'h0;
    logic [2:0] mod_order = 3'h0;
    logic [1:0] detector_loop_select = 2'h0, cal_low_compare_adjust = 2'h0;
    logic [1:0] cal_high_compare_adjust = 2'h0;
    logic [3:0] detector_delay_select = 4'h1;
    logic ref_doubler_en = 0, ref_prediv_en = 0, ref_mult_en = 0, ref_postdiv_en = 0;
    logic phase_seed_load = 0, reg_wr = 0;
    logic [7:0] ref_prediv = 8'h02, ref_postdiv = 8'h02;
    logic [6:0] reg_addr = 7'h00;
    logic [15:0] reg_data = 16'h0000;
    logic osc_edge, reference_input_rise, reference_input_fall, mult_edge, cal_freq_high;
    logic fb_pulse_q, ref_pulse_q, dual_loop_q, cal_busy_q, cal_done_q, tune_force_q;
    logic [11:0] inst_div_q;
    logic [3:0] delay_sel_q;
    logic [7:0] osc_band_q;
    int miscompares = 0, num_checks = 0;
    row_t rows[7] = '{'{12'h028, 3'h0, 0, 0, 8, 0}, '{12'h028, 3'h0, 1, 0, 8, 0},
        '{12'h028, 3'h0, 0, 1, 8, 0}, '{12'h028, 3'h1, 0, 0, 8, 0},
        '{12'h028, 3'h2, 0, 0, 8, 8}, '{12'h028, 3'h4, 0, 0, 8, 32},
        '{12'hfff, 3'h0, 0, 0, 1, 0}};
    logic [3:0] rp[5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
    int rx[5] = '{8, 16, 4, 32, 4};
    fndc_top fndc_top_inst (
        .mclk(mclk), .rst(rst), .int_div(int_div), .frac_num(frac_num),
        .fraction_denominator(fraction_denominator), .mod_order(mod_order),
        .presc_div4(presc_div4), .oscillator_doubler_enable(oscillator_doubler_enable),
        .phase_seed(phase_seed), .phase_seed_load(phase_seed_load),
        .detector_loop_select(detector_loop_select),
        .cal_low_compare_adjust(cal_low_compare_adjust),
        .cal_high_compare_adjust(cal_high_compare_adjust),
        .detector_delay_select(detector_delay_select), .ref_doubler_en(ref_doubler_en),
        .ref_prediv_en(ref_prediv_en), .ref_mult_en(ref_mult_en),
        .ref_postdiv_en(ref_postdiv_en), .ref_prediv(ref_prediv), .ref_postdiv(ref_postdiv),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_data(reg_data), .osc_edge(osc_edge),
        .reference_input_rise(reference_input_rise),
        .reference_input_fall(reference_input_fall), .mult_edge(mult_edge),
        .cal_freq_high(cal_freq_high), .fb_pulse_q(fb_pulse_q), .inst_div_q(inst_div_q),
        .ref_pulse_q(ref_pulse_q), .dual_loop_q(dual_loop_q), .delay_sel_q(delay_sel_q),
        .cal_busy_q(cal_busy_q), .cal_done_q(cal_done_q), .tune_force_q(tune_force_q),
        .osc_band_q(osc_band_q)
    );
    fndc_osc_model fndc_osc_model_inst (
        .mclk(mclk), .rst(rst), .osc_edge(osc_edge),
        .reference_input_rise(reference_input_rise),
        .reference_input_fall(reference_input_fall), .mult_edge(mult_edge),
        .cal_freq_high(cal_freq_high)
    );
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    task automatic wait_on(input bit on_done, output int n, inout int cnt);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            cnt += (reference_input_rise === 1'b1);
        end while ((on_done ? cal_done_q : fb_pulse_q) !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            miscompares++;
            report_and_stop;
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_data <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int n, s, e, c;
        repeat (5) @(posedge mclk);
        #1 check({inst_div_q, dual_loop_q, delay_sel_q, cal_busy_q, osc_band_q},
            {12'h064, 1'b1, 4'h1, 1'b0, 8'h80});
        @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge mclk);
            int_div <= rows[i].n;
            mod_order <= rows[i].o;
            presc_div4 <= rows[i].d4;
            oscillator_doubler_enable <= rows[i].dx;
            repeat (3) wait_on(1'b0, n, c);
            s = 0;
            for (int k = 0; k < rows[i].w; k++) begin
                wait_on(1'b0, n, c);
                s += n;
            end
            e = (rows[i].d4 | rows[i].dx ? 4 : 2) * (rows[i].w * rows[i].n + (rows[i].o ? 3 : 0));
            check_range(s, e - rows[i].tol, e + rows[i].tol);
            #1 if (rows[i].o == 3'h0) check(inst_div_q, rows[i].n);
        end
        @(posedge mclk);
        int_div <= 12'h028;
        mod_order <= 3'h1;
        frac_num <= 32'h0;
        phase_seed <= 32'h8;
        repeat (2) wait_on(1'b0, n, c);
        phase_seed_load <= 1'b1;
        @(posedge mclk);
        phase_seed_load <= 1'b0;
        s = 1;
        repeat (4) begin
            wait_on(1'b0, n, c);
            s += n;
        end
        check(s, 2 * (4 * 40 + 1));
        @(posedge mclk);
        mod_order <= 3'h0;
        detector_loop_select <= 2'h3;
        cal_high_compare_adjust <= 2'h3;
        detector_delay_select <= 4'h8;
        repeat (2) @(posedge mclk);
        #1 check({dual_loop_q, delay_sel_q}, {1'b0, 4'h8});
        @(posedge mclk);
        detector_loop_select <= 2'h0;
        cal_high_compare_adjust <= 2'h0;
        cal_low_compare_adjust <= 2'h3;
        presc_div4 <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 check(dual_loop_q, 1'b1);
        foreach (rp[i]) begin
            @(posedge mclk);
            {ref_doubler_en, ref_prediv_en, ref_mult_en, ref_postdiv_en} <= rp[i];
            repeat (16) @(posedge mclk);
            n = 0;
            repeat (64) @(posedge mclk) n += (ref_pulse_q === 1'b1);
            check_range(n, rx[i] - 1, rx[i] + 1);
        end
        wr(7'h01, 16'h0008);
        wr(7'h00, 16'h0007);
        #1 check(cal_busy_q, 1'b0);
        wr(7'h00, 16'h0008);
        repeat (400) @(posedge mclk);
        wr(7'h00, 16'h0008);
        c = 0;
        wait_on(1'b1, n, c);
        check_range(c, 115, 117);
        #1 check({cal_busy_q, tune_force_q, osc_band_q}, {1'b0, 1'b0, 8'h90});
        wr(7'h00, 16'h0008);
        repeat (3) @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 check({cal_busy_q, tune_force_q, osc_band_q, inst_div_q},
            {1'b0, 1'b0, 8'h80, 12'h064});
        @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 check({cal_busy_q, dual_loop_q}, 2'h1);
        report_and_stop;
    end
endmodule // tb
